// ==== dual_watchdog.sv ====
// Dual communication watchdog with APB register access.
// Activity strobes come from logic on mclk; no synchronisers needed.
//
// Our own choice: the APB register port.
module dual_watchdog (
	// Clock, reset, enable
	input  wire logic        mclk,
	input  wire logic        reset,
	input  wire logic        ce,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Traffic strobes
	input  wire logic        pd_exchange,
	input  wire logic        app_access,
	// Process outputs
	input  wire logic [15:0] proc_out,
	output logic      [15:0] field_out,
	// Status
	output logic      [1:0]  expired,
	output logic             irq
);
	wdog_pkg::wd_cfg_s cfg;
	logic [1:0]  evt;
	logic [1:0]  evt_en;
	logic [1:0]  trig;
	logic [1:0]  act;
	logic [15:0] timeout [wdog_pkg::WD_N];
	logic [15:0] wcnt    [wdog_pkg::WD_N];
	logic [1:0]  base_cnt;
	logic        base_pulse;
	logic [16:0] tick_cnt;
	logic        wd_tick;
	logic        wr;
	logic        rd_setup;
	logic        mapped;

	function automatic logic hit(input logic [11:0] a,
		input logic [11:0] off);
		return a[11:2] == off[11:2];
	endfunction : hit

	assign wr = psel && penable && pwrite && ce;
	assign rd_setup = psel && !penable && ce;
	assign pready = 1'b1;
	assign mapped = hit(paddr, wdog_pkg::ADDR_DIVIDER)
		|| hit(paddr, wdog_pkg::ADDR_IF_TO)
		|| hit(paddr, wdog_pkg::ADDR_PD_TO)
		|| hit(paddr, wdog_pkg::ADDR_EXPIRED)
		|| hit(paddr, wdog_pkg::ADDR_EVT_STAT)
		|| hit(paddr, wdog_pkg::ADDR_EVT_CLR)
		|| hit(paddr, wdog_pkg::ADDR_EVT_EN)
		|| hit(paddr, wdog_pkg::ADDR_SAFE_VAL)
		|| hit(paddr, wdog_pkg::ADDR_SAFE_SEL);
	assign pslverr = psel && penable && !mapped;

	// Configuration registers; full 16-bit range accepted
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			cfg.divider    <= wdog_pkg::RST_DIVIDER; // [R5]
			cfg.if_timeout <= wdog_pkg::RST_IF_TO; // [R1]
			cfg.pd_timeout <= wdog_pkg::RST_PD_TO; // [R5]
			cfg.safe_value <= wdog_pkg::RST_SAFE_VAL;
			cfg.safe_sel   <= wdog_pkg::RST_SAFE_SEL;
			evt_en         <= 2'h0;
		end else if (wr) begin
			if (hit(paddr, wdog_pkg::ADDR_DIVIDER)) begin
				cfg.divider <= pwdata[15:0]; // [R2]
			end
			if (hit(paddr, wdog_pkg::ADDR_IF_TO)) begin
				cfg.if_timeout <= pwdata[15:0]; // [R3] [R13]
			end
			if (hit(paddr, wdog_pkg::ADDR_PD_TO)) begin
				cfg.pd_timeout <= pwdata[15:0]; // [R3] [R13]
			end
			if (hit(paddr, wdog_pkg::ADDR_SAFE_VAL)) begin
				cfg.safe_value <= pwdata[15:0];
			end
			if (hit(paddr, wdog_pkg::ADDR_SAFE_SEL)) begin
				cfg.safe_sel <= pwdata[1:0];
			end
			if (hit(paddr, wdog_pkg::ADDR_EVT_EN)) begin
				evt_en <= pwdata[1:0];
			end
		end
	end

	// Read data captured in setup so it is stable for the access phase
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			prdata <= 32'h0000_0000;
		end else if (rd_setup) begin
			prdata <= 32'h0000_0000;
			if (hit(paddr, wdog_pkg::ADDR_DIVIDER)) begin
				prdata[15:0] <= cfg.divider;
			end
			if (hit(paddr, wdog_pkg::ADDR_IF_TO)) begin
				prdata[15:0] <= cfg.if_timeout;
			end
			if (hit(paddr, wdog_pkg::ADDR_PD_TO)) begin
				prdata[15:0] <= cfg.pd_timeout;
			end
			if (hit(paddr, wdog_pkg::ADDR_EXPIRED)) begin
				prdata[1:0] <= expired; // [R14]
			end
			if (hit(paddr, wdog_pkg::ADDR_EVT_STAT)) begin
				prdata[1:0] <= evt;
			end
			if (hit(paddr, wdog_pkg::ADDR_EVT_EN)) begin
				prdata[1:0] <= evt_en;
			end
			if (hit(paddr, wdog_pkg::ADDR_SAFE_VAL)) begin
				prdata[15:0] <= cfg.safe_value;
			end
			if (hit(paddr, wdog_pkg::ADDR_SAFE_SEL)) begin
				prdata[1:0] <= cfg.safe_sel;
			end
		end
	end

	// 40 ns base tick from the 10 ns clock
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			base_cnt <= 2'h0;
		end else if (ce) begin
			base_cnt <= base_pulse ? 2'h0 : base_cnt + 2'h1; // [R4]
		end
	end
	assign base_pulse = ce && (base_cnt == wdog_pkg::BASE_LAST);

	// Shared watchdog tick: divider plus 2 base ticks
	// At-or-above compare: a smaller divider written mid-count still ticks
	assign wd_tick = base_pulse && (tick_cnt + wdog_pkg::TICK_STEP
		>= {1'b0, cfg.divider} + wdog_pkg::TICK_EXTRA); // [R2] [R4]
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			tick_cnt <= 17'h0_0000;
		end else if (base_pulse) begin
			tick_cnt <= wd_tick ? 17'h0_0000
				: tick_cnt + wdog_pkg::TICK_STEP;
		end
	end

	assign timeout[wdog_pkg::WD_PD] = cfg.pd_timeout;
	assign timeout[wdog_pkg::WD_IF] = cfg.if_timeout;
	assign act[wdog_pkg::WD_PD] = pd_exchange;
	assign act[wdog_pkg::WD_IF] = app_access;

	// Prescaler is shared, so expiry lands up to one tick early
	generate
		for (genvar i = 0; i < wdog_pkg::WD_N; i++) begin : g_wd
			assign trig[i] = ce && !act[i] && wd_tick && !expired[i]
				&& timeout[i] != wdog_pkg::TIMEOUT_OFF
				&& wcnt[i] >= timeout[i] - 16'h0001; // [R7] [R9]
			always_ff @(posedge mclk or posedge reset) begin
				if (reset) begin
					wcnt[i]    <= 16'h0000;
					expired[i] <= 1'b0;
				end else if (ce) begin
					if (act[i]) begin
						wcnt[i]    <= 16'h0000; // [R6]
						expired[i] <= 1'b0; // [R8] [R14]
					end else if (timeout[i] == wdog_pkg::TIMEOUT_OFF) begin
						wcnt[i]    <= 16'h0000; // [R11]
						expired[i] <= 1'b0; // [R11]
					end else if (trig[i]) begin
						expired[i] <= 1'b1; // [R14]
					end else if (wd_tick && !expired[i]) begin
						wcnt[i] <= wcnt[i] + 16'h0001;
					end
				end
			end
		end
	endgenerate

	// Sticky events; a trigger in the clear cycle still lands
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			evt <= 2'h0;
		end else if (ce) begin
			if (wr && hit(paddr, wdog_pkg::ADDR_EVT_CLR)) begin
				evt <= (evt & ~pwdata[1:0]) | trig;
			end else begin
				evt <= evt | trig;
			end
		end
	end
	assign irq = |(evt & evt_en);

	// Safe state only touches outputs; link state is not ours to change
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			field_out <= wdog_pkg::RST_SAFE_VAL;
		end else if (ce) begin
			if (|(expired & cfg.safe_sel)) begin
				field_out <= cfg.safe_value; // [R10] [R7]
			end else begin
				field_out <= proc_out;
			end
		end
	end

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (reset);

	sequence s_pd_quiet;
		!pd_exchange && cfg.pd_timeout != wdog_pkg::TIMEOUT_OFF;
	endsequence

	AST_DEFAULTS: assert property ( // [R5]
		$past(reset) |-> cfg.divider == wdog_pkg::RST_DIVIDER
			&& cfg.pd_timeout == wdog_pkg::RST_PD_TO && expired == 2'h0)
		else $error("Defaults wrong after reset");
	AST_BASE_TICK: assert property ( // [R4]
		base_pulse |=> !base_pulse [*3])
		else $error("Base tick shorter than four cycles");
	AST_PD_RESTART: assert property ( // [R6]
		ce && pd_exchange |=> wcnt[0] == 16'h0000 && !expired[0])
		else $error("Exchange did not restart watchdog");
	AST_PD_TRIGGER: assert property ( // [R7]
		trig[0] |-> wd_tick && cfg.pd_timeout != wdog_pkg::TIMEOUT_OFF
			&& wcnt[0] + 16'h0001 >= cfg.pd_timeout)
		else $error("Trigger at wrong count");
	AST_PD_HOLD: assert property ( // [R8]
		(expired[0] && ce) and s_pd_quiet |=> expired[0])
		else $error("Expiry cleared without exchange");
	AST_IF_TRIGGER: assert property ( // [R9]
		trig[1] |=> expired[1] ##1 (expired[1] || $past(app_access)
			|| cfg.if_timeout == 16'h0000))
		else $error("Interface expiry not held");
	AST_SAFE_OUT: assert property ( // [R10]
		ce && |(expired & cfg.safe_sel) |=> field_out
			== $past(cfg.safe_value))
		else $error("Outputs not in safe state");
	AST_DISABLED: assert property ( // [R11]
		cfg.pd_timeout == wdog_pkg::TIMEOUT_OFF && ce
			|=> !expired[0] && !trig[0])
		else $error("Disabled watchdog expired");
	AST_EXP_CAUSE: assert property ( // [R14]
		$rose(expired[0]) |-> $past(trig[0]))
		else $error("Expiry bit set without trigger");
	AST_EVT_STICKY: assert property ( // [R14]
		$rose(expired[1]) |-> evt[1])
		else $error("Interface event not latched");

	sequence s_if_quiet;
		!app_access && cfg.if_timeout != wdog_pkg::TIMEOUT_OFF;
	endsequence

	sequence s_base_run;
		ce [*4];
	endsequence

	// Register writes land at the access edge only
	AST_WR_DIVIDER: assert property ( // [R2]
		wr && hit(paddr, wdog_pkg::ADDR_DIVIDER)
			|=> cfg.divider == $past(pwdata[15:0]))
		else $error("Divider write lost");
	AST_WR_IF_TO: assert property ( // [R3] [R13]
		wr && hit(paddr, wdog_pkg::ADDR_IF_TO)
			|=> cfg.if_timeout == $past(pwdata[15:0]))
		else $error("Interface timeout write lost");
	AST_WR_PD_TO: assert property ( // [R3] [R13]
		wr && hit(paddr, wdog_pkg::ADDR_PD_TO)
			|=> cfg.pd_timeout == $past(pwdata[15:0]))
		else $error("Process-data timeout write lost");
	AST_WR_SAFE_SEL: assert property ( // [R10]
		wr && hit(paddr, wdog_pkg::ADDR_SAFE_SEL)
			|=> cfg.safe_sel == $past(pwdata[1:0]))
		else $error("Safe select write lost");
	AST_WR_EVT_EN: assert property ( // [R14]
		wr && hit(paddr, wdog_pkg::ADDR_EVT_EN)
			|=> evt_en == $past(pwdata[1:0]))
		else $error("Event enable write lost");

	// Read data is taken in setup and must stand for the access phase
	AST_RD_PD_TO: assert property ( // [R3]
		rd_setup && hit(paddr, wdog_pkg::ADDR_PD_TO)
			|=> prdata == {16'h0000, $past(cfg.pd_timeout)})
		else $error("Timeout read data wrong");
	AST_RD_EXPIRED: assert property ( // [R14]
		rd_setup && hit(paddr, wdog_pkg::ADDR_EXPIRED)
			|=> prdata == {30'h0, $past(expired)})
		else $error("Expiry read data wrong");

	// Prescaler chain
	AST_BASE_PERIOD: assert property ( // [R4]
		base_pulse ##1 s_base_run |-> base_pulse)
		else $error("Base tick longer than four cycles");
	AST_TICK_STEP: assert property ( // [R4]
		base_pulse && !wd_tick
			|=> tick_cnt == $past(tick_cnt) + wdog_pkg::TICK_STEP)
		else $error("Tick counter skipped");
	AST_TICK_WRAP: assert property ( // [R4]
		wd_tick |=> tick_cnt == 17'h0_0000)
		else $error("Tick counter not restarted");

	// Process-data counter only counts up on a shared tick
	AST_PD_COUNT: assert property ( // [R7]
		ce && wd_tick && !pd_exchange && !expired[0] && !trig[0]
			&& cfg.pd_timeout != wdog_pkg::TIMEOUT_OFF
			|=> wcnt[0] == $past(wcnt[0]) + 16'h0001)
		else $error("Process-data count missed a tick");
	AST_PD_WAIT: assert property ( // [R7]
		ce && !wd_tick && !pd_exchange
			&& cfg.pd_timeout != wdog_pkg::TIMEOUT_OFF |=> $stable(wcnt[0]))
		else $error("Process-data count moved between ticks");
	AST_PD_EXPIRE: assert property ( // [R7]
		trig[0] |=> expired[0])
		else $error("Process-data trigger not latched");

	// Interface watchdog mirrors the process-data one
	AST_IF_RESTART: assert property ( // [R9]
		ce && app_access |=> wcnt[1] == 16'h0000 && !expired[1])
		else $error("Access did not restart interface watchdog");
	AST_IF_HOLD: assert property ( // [R9]
		(expired[1] && ce) and s_if_quiet |=> expired[1])
		else $error("Interface expiry cleared without access");
	AST_IF_DISABLED: assert property ( // [R9]
		ce && cfg.if_timeout == wdog_pkg::TIMEOUT_OFF |=> !expired[1])
		else $error("Disabled interface watchdog expired");
	AST_IF_CAUSE: assert property ( // [R9]
		$rose(expired[1]) |-> $past(trig[1]))
		else $error("Interface expiry set without trigger");

	// Event latch: set wins over a clear in the same cycle
	AST_EVT_SET: assert property ( // [R14]
		trig[0] |=> evt[0])
		else $error("Event not set on trigger");
	AST_EVT_CLEAR: assert property ( // [R14]
		wr && hit(paddr, wdog_pkg::ADDR_EVT_CLR) && pwdata[0] && !trig[0]
			|=> !evt[0])
		else $error("Event not cleared");
	AST_EVT_HOLD: assert property ( // [R14]
		evt[0] && !(wr && hit(paddr, wdog_pkg::ADDR_EVT_CLR)) |=> evt[0])
		else $error("Event dropped without clear");

	// Outputs follow the application unless forced
	AST_FIELD_PASS: assert property ( // [R10]
		ce && (expired & cfg.safe_sel) == 2'h0
			|=> field_out == $past(proc_out))
		else $error("Outputs not passed through");
	AST_RESET_STATUS: assert property ( // [R14]
		$past(reset) |-> evt == 2'h0 && prdata == 32'h0000_0000
			&& field_out == wdog_pkg::RST_SAFE_VAL)
		else $error("Status not cleared by reset");
endmodule : dual_watchdog

// ==== wdog_pkg.sv ====
// Constants, register map and config carrier of the dual watchdog.
// Assumes a 100 MHz mclk and an APB master with 32-bit data.
// Summary of operation
// R1 - Two independent watchdogs, process-data and local interface, default 100 ms.
// R2 - One shared divider register at 0x400 sets the tick length.
// R3 - Interface timeout at 0x410, process-data timeout at 0x420, in ticks.
// R4 - One tick is divider plus 2 base ticks of 40 ns.
// R5 - Divider resets to 2498, process-data timeout to 1000.
// R6 - Each successful process-data exchange restarts the process-data timeout.
// R7 - Missing exchanges beyond enabled timeout trigger; communication state unchanged.
// R8 - Triggered process-data watchdog clears only on a later exchange; the code also clears it when the timeout is 0.
// R9 - Missing interface accesses beyond enabled timeout trigger the interface watchdog.
// R10 - A trigger forces the outputs to a configurable safe value.
// R11 - Timeout 0 disables the process-data watchdog completely.
// R12 - Master writes settings at startup only when selected.
// R13 - Timeout registers accept any value up to 65535.
// R14 - Readable expiry bits set on trigger, cleared by traffic or reset.
package wdog_pkg;
	localparam int CLK_PERIOD_NS = 10;
	localparam int BASE_TICK_NS  = 40;
	localparam int BASE_TICK_CYC =
		(BASE_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [1:0] BASE_LAST = 2'(BASE_TICK_CYC - 1);
	localparam logic [16:0] TICK_EXTRA = 17'h0_0002;
	localparam logic [16:0] TICK_STEP  = 17'h0_0001;

	localparam int WD_N  = 2;
	localparam int WD_PD = 0;
	localparam int WD_IF = 1;

	localparam logic [11:0] ADDR_DIVIDER  = 12'h0400;
	localparam logic [11:0] ADDR_IF_TO    = 12'h0410;
	localparam logic [11:0] ADDR_PD_TO    = 12'h0420;
	localparam logic [11:0] ADDR_EXPIRED  = 12'h0430;
	localparam logic [11:0] ADDR_EVT_STAT = 12'h0440;
	localparam logic [11:0] ADDR_EVT_CLR  = 12'h0444;
	localparam logic [11:0] ADDR_EVT_EN   = 12'h0448;
	localparam logic [11:0] ADDR_SAFE_VAL = 12'h0450;
	localparam logic [11:0] ADDR_SAFE_SEL = 12'h0454;

	localparam logic [15:0] RST_DIVIDER  = 16'h09c2;
	localparam logic [15:0] RST_PD_TO    = 16'h03e8;
	localparam logic [15:0] RST_IF_TO    = 16'h03e8;
	localparam logic [15:0] RST_SAFE_VAL = 16'h0000;
	localparam logic [1:0]  RST_SAFE_SEL = 2'h3;
	localparam logic [15:0] TIMEOUT_OFF  = 16'h0000;

	typedef struct packed {
		logic [15:0] divider;
		logic [15:0] if_timeout;
		logic [15:0] pd_timeout;
		logic [15:0] safe_value;
		logic [1:0]  safe_sel;
	} wd_cfg_s;
endpackage : wdog_pkg

// ==== traffic_partner.sv ====
// Far-side model: fieldbus master exchanges and local application accesses.
// Assumes bench requests on mclk; emits one-cycle activity strobes.
module traffic_partner (
	// Clock and reset
	input  wire logic mclk,
	input  wire logic reset,
	// Requests from the bench
	input  wire logic pd_req,
	input  wire logic app_req,
	// Activity strobes
	output logic      pd_exchange,
	output logic      app_access
);
	timeunit 1ns;
	timeprecision 1ps;
	// Registered so strobes never change on the sampling edge
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			pd_exchange <= 1'b0;
		end else begin
			pd_exchange <= pd_req;
		end
	end
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			app_access <= 1'b0;
		end else begin
			app_access <= app_req;
		end
	end
endmodule : traffic_partner

// ==== dual_watchdog_bench.sv ====
// Self-checking bench for dual_watchdog over APB with a traffic model.
// Assumes wdog_pkg, dual_watchdog and traffic_partner compiled first.
module dual_watchdog_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        mclk, reset, psel, penable, pwrite, pready, pslverr, irq;
	logic        pd_req, app_req, pd_exchange, app_access;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rnd;
	logic [15:0] proc_out, field_out;
	logic [1:0]  expired;
	logic [31:0] exp_q[$];
	int          bad_count, n_tests;

	dual_watchdog u_dual_watchdog (.mclk(mclk), .reset(reset), .ce(1'b1),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pd_exchange(pd_exchange),
		.app_access(app_access), .proc_out(proc_out),
		.field_out(field_out), .expired(expired), .irq(irq));
	traffic_partner u_traffic_partner (.mclk(mclk), .reset(reset),
		.pd_req(pd_req), .app_req(app_req), .pd_exchange(pd_exchange),
		.app_access(app_access));

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction : lfsr

	task automatic chk(input string nm, input logic [31:0] seen, exp);
		n_tests++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic end_sim();
		if (bad_count == 0 && n_tests > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : end_sim

	// Idle edge first, so psel is never assigned twice in one step
	task automatic apb(input logic [11:0] a, input logic w,
		input logic [31:0] d);
		int n;
		@(posedge mclk);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 100);
		if (n >= 100) begin
			bad_count++;
			end_sim();
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(a, 1'b1, d);
	endtask : wr

	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		apb(a, 1'b0, 32'h0000_0000);
	endtask : rd

	task automatic kick(input logic pd);
		@(posedge mclk);
		pd_req <= pd;
		app_req <= !pd;
		@(posedge mclk);
		pd_req <= 1'b0;
		app_req <= 1'b0;
	endtask : kick

	always @(posedge mclk) begin
		if (psel && penable && pready) begin
			chk("pslverr", {31'h0, pslverr}, {31'h0, paddr == 12'h3fc});
			if (!pwrite) begin
				chk("prdata", prdata, exp_q.pop_front());
			end
		end
	end

	initial begin
		#50us;
		bad_count++;
		end_sim();
	end

	initial begin
		reset = 1'b1;
		{psel, penable, pwrite, pd_req, app_req} = 5'h00;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		proc_out = 16'h0000;
		rnd = lfsr(32'h5e60_f84f);
		repeat (2) @(posedge mclk);
		reset <= 1'b0;
		rd(wdog_pkg::ADDR_DIVIDER, 32'h0000_09c2);
		rd(wdog_pkg::ADDR_PD_TO, 32'h0000_03e8);
		rd(wdog_pkg::ADDR_IF_TO, 32'h0000_03e8);
		rd(12'h3fc, 32'h0000_0000);
		wr(wdog_pkg::ADDR_IF_TO, 32'h0000_ffff);
		rd(wdog_pkg::ADDR_IF_TO, 32'h0000_ffff);
		wr(wdog_pkg::ADDR_IF_TO, 32'h0000_0000);
		wr(wdog_pkg::ADDR_SAFE_VAL, {16'h0000, rnd[15:0]});
		proc_out <= rnd[31:16];
		wr(wdog_pkg::ADDR_EVT_EN, 32'h0000_0001);
		wr(wdog_pkg::ADDR_DIVIDER, 32'h0000_0000);
		wr(wdog_pkg::ADDR_PD_TO, 32'h0000_0002);
		kick(1'b1);
		rd(wdog_pkg::ADDR_EXPIRED, 32'h0000_0000);
		repeat (24) @(posedge mclk);
		rd(wdog_pkg::ADDR_EXPIRED, 32'h0000_0001);
		chk("irq", {31'h0, irq}, 32'h0000_0001);
		chk("field_out", {16'h0, field_out}, {16'h0, rnd[15:0]});
		kick(1'b1);
		rd(wdog_pkg::ADDR_EXPIRED, 32'h0000_0000);
		wr(wdog_pkg::ADDR_PD_TO, 32'h0000_0000);
		rd(wdog_pkg::ADDR_EVT_STAT, 32'h0000_0001);
		wr(wdog_pkg::ADDR_EVT_CLR, 32'h0000_0001);
		rd(wdog_pkg::ADDR_EVT_STAT, 32'h0000_0000);
		chk("irq", {31'h0, irq}, 32'h0000_0000);
		repeat (40) @(posedge mclk);
		rd(wdog_pkg::ADDR_EXPIRED, 32'h0000_0000);
		chk("field_out", {16'h0, field_out}, {16'h0, rnd[31:16]});
		wr(wdog_pkg::ADDR_IF_TO, 32'h0000_0002);
		kick(1'b0);
		repeat (24) @(posedge mclk);
		rd(wdog_pkg::ADDR_EXPIRED, 32'h0000_0002);
		@(posedge mclk);
		end_sim();
	end
endmodule : dual_watchdog_bench
